// *** pmic_regs_pkg.sv ***
// constants shared by the switch and recovery register bank
package pmic_regs_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] LDO_VOLTAGE_SELECT_OFS          = 8'h04;
    localparam logic [7:0] SWITCH_PULLDOWN_CONTROL_OFS     = 8'h05;
    localparam logic [7:0] MAXRAIL_RECOVERY_THRESHOLDS_OFS = 8'h06;
    localparam logic [7:0] ALARM_AND_INTERCONNECT_OFS      = 8'h07;

    // ****************************************
    // field positions
    // ****************************************
    localparam int LDO_CODE_MSB     = 4;
    localparam int BANDGAP_EN_BIT   = 5;
    localparam int PD_FAST_BIT      = 0;
    localparam int PD_SERIAL_BIT    = 1;
    localparam int PD_BBSW2_BIT     = 2;
    localparam int PD_MAXRAIL_BIT   = 3;
    localparam int PD_REGSW1_BIT    = 4;
    localparam int PD_REGSW2_BIT    = 5;
    localparam int PD_BBSW1_BIT     = 6;
    localparam int PD_BATTERY_BIT   = 7;
    localparam int RISE_LSB         = 0;
    localparam int FALL_LSB         = 3;
    localparam int MAXRAIL_ON_BIT   = 6;
    localparam int MAXRAIL_OFF_BIT  = 7;
    localparam int TIE_SW_BIT       = 0;
    localparam int SEL_BB_BIT       = 1;
    localparam int OT_LIVE_BIT      = 2;
    localparam int UV_LIVE_BIT      = 3;
    localparam int OT_MASK_BIT      = 4;
    localparam int UV_MASK_BIT      = 5;
    localparam int OT_LATCH_BIT     = 6;
    localparam int UV_LATCH_BIT     = 7;

    // ****************************************
    // codes and power-up values
    // ****************************************
    localparam logic [4:0] LDO_CODE_RESERVED = 5'h1f;
    localparam logic [5:0] LDO_RESET         = 6'h12;
    localparam logic [7:0] PULLDOWN_RESET    = 8'hc2;
    localparam logic [7:0] RECOVERY_RESET    = 8'h18;
    localparam logic [1:0] INTERCONNECT_RESET = 2'h0;
    localparam logic       UV_MASK_RESET     = 1'b0;
    localparam logic       OT_MASK_RESET     = 1'b1;
endpackage

// *** alarm_if.sv ***
// alarm signals between the register bank and the alarm unit
interface alarm_if;
    logic uv_mask;
    logic ot_mask;
    logic rd_clear;
    logic uv_latch;
    logic ot_latch;
    logic uv_live;
    logic ot_live;
    logic alarm;

    modport bank (output uv_mask, output ot_mask, output rd_clear,
                  input uv_latch, input ot_latch, input uv_live, input ot_live, input alarm);
    modport unit (input uv_mask, input ot_mask, input rd_clear,
                  output uv_latch, output ot_latch, output uv_live, output ot_live,
                  output alarm);
endinterface

// *** alarm_unit.sv ***
// recovery hysteresis, alarm latches and alarm pin
module alarm_unit
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_sync_b,
    // comparator and sensor levels
    input  wire logic below_fall_cmp,
    input  wire logic above_rise_cmp,
    input  wire logic overtemp_cmp,
    // to the register bank
    alarm_if.unit     al
);
    logic recovery_alarm_r;
    logic uv_latch_r;
    logic ot_latch_r;
    logic ot_live_r;
    logic alarm_r;
    logic uv_event;
    logic ot_event;

    // ****************************************
    // hysteresis
    // ****************************************
    // falling trip dominates so a glitchy rising compare never masks a brown-out
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            recovery_alarm_r <= 1'b0;
        else if (below_fall_cmp)
            recovery_alarm_r <= 1'b1;
        else if (above_rise_cmp)
            recovery_alarm_r <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            ot_live_r <= 1'b0;
        else
            ot_live_r <= overtemp_cmp;
    end

    // ****************************************
    // latches
    // ****************************************
    assign uv_event = below_fall_cmp && !recovery_alarm_r;
    assign ot_event = overtemp_cmp && !ot_live_r;

    // set beats the read clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            uv_latch_r <= 1'b0;
            ot_latch_r <= 1'b0;
        end
        else
        begin
            uv_latch_r <= uv_event || (uv_latch_r && !al.rd_clear);
            ot_latch_r <= ot_event || (ot_latch_r && !al.rd_clear);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            alarm_r <= 1'b0;
        else
            alarm_r <= (recovery_alarm_r && !al.uv_mask) || (ot_latch_r && !al.ot_mask);
    end

    assign al.uv_latch = uv_latch_r;
    assign al.ot_latch = ot_latch_r;
    assign al.uv_live  = recovery_alarm_r;
    assign al.ot_live  = ot_live_r;
    assign al.alarm    = alarm_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    AST_HYST_HOLD: assert property (
        recovery_alarm_r && !above_rise_cmp |=> recovery_alarm_r)
        else $error("recovery alarm dropped before rising threshold");
    // mask as it stood when the pin was computed, not after a later write
    AST_HYST_TRIP: assert property (
        below_fall_cmp |=> recovery_alarm_r ##1 (alarm_r || $past(al.uv_mask)))
        else $error("falling trip did not raise alarm state");
    AST_UV_SET: assert property (uv_event |=> uv_latch_r)
        else $error("undervoltage latch not set on falling trip");
    AST_UV_NOSET_RELEASE: assert property (
        $fell(recovery_alarm_r) && !$past(al.uv_latch) && !below_fall_cmp |-> !uv_latch_r)
        else $error("undervoltage latch set on release");
    AST_OT_SET: assert property (ot_event |=> ot_latch_r)
        else $error("overtemperature latch not set");
    AST_CLEAR: assert property (
        al.rd_clear && !uv_event && !ot_event |=> !uv_latch_r && !ot_latch_r)
        else $error("read did not clear latches");
    AST_SET_WINS: assert property (al.rd_clear && uv_event |=> uv_latch_r)
        else $error("clear beat a coincident set");

    COV_TRIP_RECOVER: cover property (recovery_alarm_r ##[1:20] !recovery_alarm_r);
    COV_OT_CLEAR: cover property (ot_latch_r ##[1:20] !ot_latch_r);
endmodule

// *** pmic_switch_recovery_regs.sv ***
// configuration and alarm register bank of the power switches and recovery comparator
module pmic_switch_recovery_regs
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // register access
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // analog status
    input  wire logic       below_fall_cmp,
    input  wire logic       above_rise_cmp,
    input  wire logic       overtemp_cmp,
    // ldo control
    output logic      [4:0] ldo_level_code,
    output logic            bandgap_en,
    // pulldown and turn-on
    output logic            pd_battery_switch_en,
    output logic            pd_bbsw1_en,
    output logic            pd_regsw2_en,
    output logic            pd_regsw1_en,
    output logic            pd_maxrail_switch_en,
    output logic            pd_bbsw2_en,
    output logic            pd_serial_pins_en,
    output logic            fast_turnon,
    // max rail and thresholds
    output logic            maxrail_off_ctl,
    output logic            maxrail_on_ctl,
    output logic      [2:0] falling_threshold_code,
    output logic      [2:0] rising_threshold_code,
    // interconnect and alarm
    output logic            select_from_buckboost_en,
    output logic            regulator_tie_switch_en,
    output logic            alarm_out
);
    logic [1:0] rst_pipe_r;
    logic       rst_sync_b;
    logic [5:0] ldo_r;
    logic [7:0] pd_r;
    logic [7:0] rec_r;
    logic [1:0] sw_r;
    logic       uv_mask_r;
    logic       ot_mask_r;
    logic [7:0] rdata_r;
    logic [7:0] alarm_view;
    logic       wr_ldo;
    logic       wr_pd;
    logic       wr_rec;
    logic       wr_alarm;

    alarm_if al ();

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ****************************************
    // reset release
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_pipe_r <= 2'h0;
        else
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
    assign rst_sync_b = rst_pipe_r[1];

    // ****************************************
    // write decode
    // ****************************************
    assign wr_ldo   = reg_wr && hit(reg_addr, pmic_regs_pkg::LDO_VOLTAGE_SELECT_OFS);
    assign wr_pd    = reg_wr && hit(reg_addr, pmic_regs_pkg::SWITCH_PULLDOWN_CONTROL_OFS);
    assign wr_rec   = reg_wr && hit(reg_addr, pmic_regs_pkg::MAXRAIL_RECOVERY_THRESHOLDS_OFS);
    assign wr_alarm = reg_wr && hit(reg_addr, pmic_regs_pkg::ALARM_AND_INTERCONNECT_OFS);

    // ****************************************
    // registers
    // ****************************************
    // reserved code kept out: it would drop the rail far below the table
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            ldo_r <= pmic_regs_pkg::LDO_RESET;
        else if (wr_ldo)
        begin
            ldo_r[pmic_regs_pkg::BANDGAP_EN_BIT] <= reg_wdata[pmic_regs_pkg::BANDGAP_EN_BIT];
            if (reg_wdata[pmic_regs_pkg::LDO_CODE_MSB:0] != pmic_regs_pkg::LDO_CODE_RESERVED)
                ldo_r[pmic_regs_pkg::LDO_CODE_MSB:0] <=
                    reg_wdata[pmic_regs_pkg::LDO_CODE_MSB:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            pd_r <= pmic_regs_pkg::PULLDOWN_RESET;
        else if (wr_pd)
            pd_r <= reg_wdata;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            rec_r <= pmic_regs_pkg::RECOVERY_RESET;
        else if (wr_rec)
            rec_r <= reg_wdata;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            sw_r      <= pmic_regs_pkg::INTERCONNECT_RESET;
            uv_mask_r <= pmic_regs_pkg::UV_MASK_RESET;
            ot_mask_r <= pmic_regs_pkg::OT_MASK_RESET;
        end
        else if (wr_alarm)
        begin
            sw_r      <=
                reg_wdata[pmic_regs_pkg::SEL_BB_BIT:pmic_regs_pkg::TIE_SW_BIT];
            uv_mask_r <= reg_wdata[pmic_regs_pkg::UV_MASK_BIT];
            ot_mask_r <= reg_wdata[pmic_regs_pkg::OT_MASK_BIT];
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb
    begin
        alarm_view = 8'h00;
        alarm_view[pmic_regs_pkg::UV_LATCH_BIT] = al.uv_latch;
        alarm_view[pmic_regs_pkg::OT_LATCH_BIT] = al.ot_latch;
        alarm_view[pmic_regs_pkg::UV_MASK_BIT]  = uv_mask_r;
        alarm_view[pmic_regs_pkg::OT_MASK_BIT]  = ot_mask_r;
        alarm_view[pmic_regs_pkg::UV_LIVE_BIT]  = al.uv_live;
        alarm_view[pmic_regs_pkg::OT_LIVE_BIT]  = al.ot_live;
        alarm_view[pmic_regs_pkg::SEL_BB_BIT:pmic_regs_pkg::TIE_SW_BIT] = sw_r;
    end

    // unmapped offsets read as zero
    always_ff @(posedge core_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            rdata_r <= 8'h00;
        else if (reg_rd)
        begin
            if (hit(reg_addr, pmic_regs_pkg::LDO_VOLTAGE_SELECT_OFS))
                rdata_r <= {2'h0, ldo_r};
            else if (hit(reg_addr, pmic_regs_pkg::SWITCH_PULLDOWN_CONTROL_OFS))
                rdata_r <= pd_r;
            else if (hit(reg_addr, pmic_regs_pkg::MAXRAIL_RECOVERY_THRESHOLDS_OFS))
                rdata_r <= rec_r;
            else if (hit(reg_addr, pmic_regs_pkg::ALARM_AND_INTERCONNECT_OFS))
                rdata_r <= alarm_view;
            else
                rdata_r <= 8'h00;
        end
    end
    assign reg_rdata = rdata_r;

    assign al.uv_mask  = uv_mask_r;
    assign al.ot_mask  = ot_mask_r;
    assign al.rd_clear = reg_rd &&
        hit(reg_addr, pmic_regs_pkg::ALARM_AND_INTERCONNECT_OFS);

    alarm_unit u_alarm
    (
        .core_clk       (core_clk),
        .rst_sync_b     (rst_sync_b),
        .below_fall_cmp (below_fall_cmp),
        .above_rise_cmp (above_rise_cmp),
        .overtemp_cmp   (overtemp_cmp),
        .al             (al)
    );

    // ****************************************
    // control outputs
    // ****************************************
    assign ldo_level_code       = ldo_r[pmic_regs_pkg::LDO_CODE_MSB:0];
    assign bandgap_en           = ldo_r[pmic_regs_pkg::BANDGAP_EN_BIT];
    assign pd_battery_switch_en = pd_r[pmic_regs_pkg::PD_BATTERY_BIT];
    assign pd_bbsw1_en          = pd_r[pmic_regs_pkg::PD_BBSW1_BIT];
    assign pd_regsw2_en         = pd_r[pmic_regs_pkg::PD_REGSW2_BIT];
    assign pd_regsw1_en         = pd_r[pmic_regs_pkg::PD_REGSW1_BIT];
    assign pd_maxrail_switch_en = pd_r[pmic_regs_pkg::PD_MAXRAIL_BIT];
    assign pd_bbsw2_en          = pd_r[pmic_regs_pkg::PD_BBSW2_BIT];
    assign pd_serial_pins_en    = pd_r[pmic_regs_pkg::PD_SERIAL_BIT];
    assign fast_turnon          = pd_r[pmic_regs_pkg::PD_FAST_BIT];
    assign maxrail_off_ctl      = rec_r[pmic_regs_pkg::MAXRAIL_OFF_BIT];
    assign maxrail_on_ctl       = rec_r[pmic_regs_pkg::MAXRAIL_ON_BIT];
    // plain binary codes, so code 6 is 110 and the steps stay monotonic
    assign falling_threshold_code = rec_r[pmic_regs_pkg::FALL_LSB +: 3];
    assign rising_threshold_code  = rec_r[pmic_regs_pkg::RISE_LSB +: 3];
    assign select_from_buckboost_en = sw_r[pmic_regs_pkg::SEL_BB_BIT];
    assign regulator_tie_switch_en  = sw_r[pmic_regs_pkg::TIE_SW_BIT];
    assign alarm_out              = al.alarm;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    AST_LDO_NO_RESERVED: assert property (
        ldo_level_code != pmic_regs_pkg::LDO_CODE_RESERVED)
        else $error("reserved ldo code reached the output");
    AST_LDO_WRITE: assert property (
        wr_ldo && reg_wdata[pmic_regs_pkg::LDO_CODE_MSB:0] != pmic_regs_pkg::LDO_CODE_RESERVED
        |=> ldo_level_code == $past(reg_wdata[pmic_regs_pkg::LDO_CODE_MSB:0]))
        else $error("ldo code write not applied");
    AST_PD_MAP: assert property (
        wr_pd |=> {pd_battery_switch_en, pd_bbsw1_en, pd_regsw2_en, pd_regsw1_en,
                   pd_maxrail_switch_en, pd_bbsw2_en} == $past(reg_wdata[7:2]))
        else $error("pulldown bit map wrong");
    AST_SERIAL_FAST: assert property (
        wr_pd |=> pd_serial_pins_en == $past(reg_wdata[1]) &&
                  fast_turnon == $past(reg_wdata[0]))
        else $error("serial pulldown or fast bit wrong");
    AST_THRESH: assert property (
        wr_rec |=> falling_threshold_code == $past(reg_wdata[5:3]) &&
                   rising_threshold_code == $past(reg_wdata[2:0]) &&
                   maxrail_on_ctl == $past(reg_wdata[6]))
        else $error("threshold fields wrong");
    AST_TIE: assert property (
        wr_alarm |=> regulator_tie_switch_en == $past(reg_wdata[0]) &&
                     select_from_buckboost_en == $past(reg_wdata[1]))
        else $error("interconnect switches wrong");
    AST_ALARM_READ: assert property (
        reg_rd && hit(reg_addr, pmic_regs_pkg::ALARM_AND_INTERCONNECT_OFS)
        |=> reg_rdata[7] == $past(al.uv_latch) && reg_rdata[3] == $past(al.uv_live))
        else $error("alarm read data wrong");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h07 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    COV_LDO_REFUSED: cover property (wr_ldo && reg_wdata[4:0] == 5'h1f);
    COV_ALARM_PIN: cover property (alarm_out ##[1:30] !alarm_out);
    COV_READ_CLEAR: cover property (al.uv_latch && al.rd_clear);
endmodule

// *** tb_pmic_switch_recovery_regs.sv ***
// self-checking bench for the switch and recovery register bank
module tb_pmic_switch_recovery_regs;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // signals
    // ****************************************
    logic       core_clk;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       below_fall_cmp;
    logic       above_rise_cmp;
    logic       overtemp_cmp;
    logic [4:0] ldo_level_code;
    logic       bandgap_en;
    logic       pd_battery_switch_en;
    logic       pd_bbsw1_en;
    logic       pd_regsw2_en;
    logic       pd_regsw1_en;
    logic       pd_maxrail_switch_en;
    logic       pd_bbsw2_en;
    logic       pd_serial_pins_en;
    logic       fast_turnon;
    logic       maxrail_off_ctl;
    logic       maxrail_on_ctl;
    logic [2:0] falling_threshold_code;
    logic [2:0] rising_threshold_code;
    logic       select_from_buckboost_en;
    logic       regulator_tie_switch_en;
    logic       alarm_out;
    logic [7:0] pd_vec;
    int         n_mismatch;
    int         total_checks;

    assign pd_vec = {pd_battery_switch_en, pd_bbsw1_en, pd_regsw2_en, pd_regsw1_en,
                     pd_maxrail_switch_en, pd_bbsw2_en, pd_serial_pins_en, fast_turnon};

    pmic_switch_recovery_regs dut
    (
        .core_clk                 (core_clk),
        .rst_b                    (rst_b),
        .reg_addr                 (reg_addr),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_wdata                (reg_wdata),
        .reg_rdata                (reg_rdata),
        .below_fall_cmp           (below_fall_cmp),
        .above_rise_cmp           (above_rise_cmp),
        .overtemp_cmp             (overtemp_cmp),
        .ldo_level_code           (ldo_level_code),
        .bandgap_en               (bandgap_en),
        .pd_battery_switch_en     (pd_battery_switch_en),
        .pd_bbsw1_en              (pd_bbsw1_en),
        .pd_regsw2_en             (pd_regsw2_en),
        .pd_regsw1_en             (pd_regsw1_en),
        .pd_maxrail_switch_en     (pd_maxrail_switch_en),
        .pd_bbsw2_en              (pd_bbsw2_en),
        .pd_serial_pins_en        (pd_serial_pins_en),
        .fast_turnon              (fast_turnon),
        .maxrail_off_ctl          (maxrail_off_ctl),
        .maxrail_on_ctl           (maxrail_on_ctl),
        .falling_threshold_code   (falling_threshold_code),
        .rising_threshold_code    (rising_threshold_code),
        .select_from_buckboost_en (select_from_buckboost_en),
        .regulator_tie_switch_en  (regulator_tie_switch_en),
        .alarm_out                (alarm_out)
    );

    always #2 core_clk = ~core_clk;

    // ****************************************
    // tasks
    // ****************************************
    task automatic give_verdict();
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        cycles(1);
        reg_wr    = 1'b0;
        cycles(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        reg_addr = a;
        reg_rd   = 1'b1;
        cycles(1);
        reg_rd   = 1'b0;
        chk(name, exp, reg_rdata);
        cycles(1);
    endtask

    task automatic pulse_cmp(input bit fall);
        if (fall)
            below_fall_cmp = 1'b1;
        else
            above_rise_cmp = 1'b1;
        cycles(1);
        below_fall_cmp = 1'b0;
        above_rise_cmp = 1'b0;
        cycles(2);
    endtask

    // ****************************************
    // watchdog
    // ****************************************
    initial
    begin
        #20000;
        n_mismatch++;
        give_verdict();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        logic [2:0] k;
        core_clk = 1'b0;
        rst_b = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {below_fall_cmp, above_rise_cmp, overtemp_cmp} = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (12) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        cycles(3);
        chk("pulldown outputs", 8'hc2, pd_vec);
        chk("maxrail ctl", 8'h00, {maxrail_off_ctl, maxrail_on_ctl});
        rd(8'h04, 8'h12, "ldo reg");
        rd(8'h05, 8'hc2, "pulldown reg");
        rd(8'h06, 8'h18, "recovery reg");
        rd(8'h07, 8'h10, "alarm reg");
        rd(8'h08, 8'h00, "unmapped");
        // code 31 must never reach the regulator
        wr(8'h04, 8'h3e);
        chk("ldo code 30", 8'h1e, ldo_level_code);
        chk("bandgap on", 8'h01, bandgap_en);
        wr(8'h04, 8'h1f);
        chk("ldo code kept", 8'h1e, ldo_level_code);
        chk("bandgap off", 8'h00, bandgap_en);
        rd(8'h04, 8'h1e, "ldo reg after 31");
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h3e, "ldo reserved bits");
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h05, 8'h01 << i);
            chk("pulldown one-hot", 8'h01 << i, pd_vec);
            rd(8'h05, 8'h01 << i, "pulldown readback");
        end
        for (int i = 0; i < 8; i++)
        begin
            k = i[2:0];
            wr(8'h06, {k[1:0], k, ~k});
            chk("falling code", {5'h00, k}, falling_threshold_code);
            chk("rising code", {5'h00, ~k}, rising_threshold_code);
            chk("maxrail ctl", {6'h00, k[1:0]}, {maxrail_off_ctl, maxrail_on_ctl});
            rd(8'h06, {k[1:0], k, ~k}, "recovery readback");
        end
        wr(8'h08, 8'hff);
        rd(8'h05, 8'h80, "pulldown after unmapped write");
        // read-only alarm bits must ignore the write
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h33, "alarm reg rw bits");
        chk("interconnect", 8'h03,
            {select_from_buckboost_en, regulator_tie_switch_en});
        wr(8'h07, 8'h03);
        pulse_cmp(1'b1);
        chk("alarm pin on fall", 8'h01, alarm_out);
        rd(8'h07, 8'h8b, "uv latch and live");
        rd(8'h07, 8'h0b, "uv latch cleared");
        chk("alarm pin held", 8'h01, alarm_out);
        pulse_cmp(1'b0);
        chk("alarm pin released", 8'h00, alarm_out);
        rd(8'h07, 8'h03, "no latch on release");
        wr(8'h07, 8'h23);
        pulse_cmp(1'b1);
        chk("uv masked pin", 8'h00, alarm_out);
        rd(8'h07, 8'hab, "uv latch masked");
        pulse_cmp(1'b0);
        wr(8'h07, 8'h03);
        overtemp_cmp = 1'b1;
        cycles(3);
        chk("ot alarm pin", 8'h01, alarm_out);
        rd(8'h07, 8'h47, "ot latch and live");
        cycles(2);
        chk("ot pin after read", 8'h00, alarm_out);
        rd(8'h07, 8'h07, "ot latch cleared");
        overtemp_cmp = 1'b0;
        wr(8'h07, 8'h13);
        overtemp_cmp = 1'b1;
        cycles(3);
        chk("ot masked pin", 8'h00, alarm_out);
        rd(8'h07, 8'h57, "ot latch masked");
        overtemp_cmp = 1'b0;
        // trip lands on the very edge of a clearing read: the set must survive
        below_fall_cmp = 1'b1;
        rd(8'h07, 8'h17, "read during uv trip");
        below_fall_cmp = 1'b0;
        rd(8'h07, 8'h9b, "uv latch set beats clear");
        // mid-run reset must restore stored defaults
        rst_b = 1'b0;
        cycles(2);
        chk("alarm pin after reset", 8'h00, alarm_out);
        chk("rdata after reset", 8'h00, reg_rdata);
        chk("pulldown after reset", 8'hc2, pd_vec);
        chk("ldo after reset", 8'h12, ldo_level_code);
        rst_b = 1'b1;
        cycles(3);
        rd(8'h06, 8'h18, "recovery after reset");
        give_verdict();
    end
endmodule
